// ---- common/nfc_consts.vh ----
/*
  Constants for the flash host sequencer: command codes, operation codes,
  address layout and strobe timing counts.
  Assumes a 250 MHz sequencer clock; timing figures below are in ns, page sizes in bytes.
*/
`ifndef NFC_CONSTS_VH
`define NFC_CONSTS_VH

`define NFC_CLK_NS        8'h04

`define NFC_T_WLOW_NS     8'h0F
`define NFC_T_WH_NS       8'h0A
`define NFC_T_WHR_NS      8'h3C
`define NFC_T_RLOW_NS     8'h18
`define NFC_T_REH_NS      8'h0A
`define NFC_T_WB_NS       8'h64

`define NFC_CYC_WLOW      ((`NFC_T_WLOW_NS + `NFC_CLK_NS - 8'h01) / `NFC_CLK_NS)
`define NFC_CYC_WH        ((`NFC_T_WH_NS + `NFC_CLK_NS - 8'h01) / `NFC_CLK_NS)
`define NFC_CYC_WHR       ((`NFC_T_WHR_NS + `NFC_CLK_NS - 8'h01) / `NFC_CLK_NS)
`define NFC_CYC_RLOW      ((`NFC_T_RLOW_NS + `NFC_CLK_NS - 8'h01) / `NFC_CLK_NS)
`define NFC_CYC_REH       ((`NFC_T_REH_NS + `NFC_CLK_NS - 8'h01) / `NFC_CLK_NS)
`define NFC_CYC_WB        ((`NFC_T_WB_NS + `NFC_CLK_NS - 8'h01) / `NFC_CLK_NS)

`define NFC_OP_CMD        3'h0
`define NFC_OP_ADDR5      3'h1
`define NFC_OP_ADDR2      3'h2
`define NFC_OP_WRITE      3'h3
`define NFC_OP_READ       3'h4
`define NFC_OP_WAIT       3'h5

`define NFC_CMD_READ1     8'h00
`define NFC_CMD_READ2     8'h30
`define NFC_CMD_COLOUT1   8'h05
`define NFC_CMD_COLOUT2   8'hE0
`define NFC_CMD_RDCACHE   8'h31
`define NFC_CMD_RDLAST    8'h3F
`define NFC_CMD_DATAIN    8'h80
`define NFC_CMD_PROG      8'h10
`define NFC_CMD_PROGCACHE 8'h15
`define NFC_CMD_PROGMULTI 8'h11
`define NFC_CMD_COLIN     8'h85
`define NFC_CMD_COPYPROG  8'h8C
`define NFC_CMD_STATUS    8'h70
`define NFC_CMD_STATMULTI 8'h71
`define NFC_CMD_RESET     8'hFF

`define NFC_PAGE_BYTES    13'h10E0
`define NFC_MAIN_BYTES    13'h1000
`define NFC_SPARE_BYTES   13'h00E0
`define NFC_PAGES_PER_BLK 7'h40
`define NFC_PAGE_IDX_MSB  5
`define NFC_BLOCK_LSB     6
`define NFC_ROW_MSB       17

`define NFC_ST_CUR_FAIL   0
`define NFC_ST_PREV_FAIL  1
`define NFC_ST_BUF_READY  5
`define NFC_ST_CACHE_RDY  6

`define NFC_INIT_SELECT   1'b0

`endif

// ---- rtl/nfc_addr_pack.v ----
/*
  Five-byte address packer: stores column and row and hands out one
  address byte per cycle, least significant first, from a register.
  Assumes load and index come from the sequencer in the same clock domain.
*/
`timescale 1ns/10ps
`include "nfc_consts.vh"

module nfc_addr_pack (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        load,
  input  wire [2:0]  index,
  input  wire [12:0] columnBits,
  input  wire [17:0] rowBits,
  output reg  [7:0]  addrByte
);

  reg [12:0] colHeld;
  reg [17:0] rowHeld;

  // Unused upper bits of both fields go out low
  function [7:0] packByte;
    input [12:0] col;
    input [17:0] row;
    input [2:0]  idx;
    begin
      case (idx)
        3'h0:    packByte = col[7:0];
        3'h1:    packByte = {3'h0, col[12:8]};
        3'h2:    packByte = row[7:0];
        3'h3:    packByte = row[15:8];
        3'h4:    packByte = {6'h00, row[`NFC_ROW_MSB:16]};
        default: packByte = 8'h00;
      endcase
    end
  endfunction

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      colHeld  <= 13'h0000;
      rowHeld  <= 18'h00000;
      addrByte <= 8'h00;
    end else if (load) begin
      colHeld  <= columnBits;
      rowHeld  <= rowBits;
      addrByte <= packByte(columnBits, rowBits, 3'h0); // RULE9
    end else begin
      addrByte <= packByte(colHeld, rowHeld, index); // RULE9
    end
  end

endmodule

// ---- rtl/nfc_host_seq.v ----
/*
  Host-side sequencer for an 8-bit page flash: runs one bus cycle group per
  user request (command, 5 or 2 address bytes, data in, data out, wait ready).
  Assumes ioBusIn and ready_busy_n are synchronous to ref_clk and the pin
  pull-up on ready/busy lives outside.
*/
// Operation
// RULE1: Command latched on write strobe rise, CLE high
// RULE2: Address latched on write strobe rise, ALE high
// RULE3: Strobe levels select command, address, data, output
// RULE4: Read strobe fall outputs byte, column increments
// RULE5: Device drives bus only while read strobe low
// RULE6: Chip select rise when ready enters standby
// RULE7: Write protect low blocks program and erase
// RULE8: Ready/busy low during operations, high after
// RULE9: Five address bytes, low first, unused bits low
// RULE10: Row bits 6-17 block, 0-5 page
// RULE11: Page 4320 bytes, 4096 main, 224 spare
// RULE12: Page read is 00h, five addresses, 30h
// RULE13: Read commands 05/E0, 31, 3F decoded
// RULE14: Program 80 then 10/15/11; 85 column
// RULE15: Copy program 8C then 15 or 10
// RULE16: Only 70, 71, FF accepted while busy
// RULE17: During read busy strobes stay high
// RULE18: Cached program must end with 80h-10h
// RULE19: After ending 15h, poll 70h, then FFh
// RULE20: Init select pin held at static level
// RULE21: Status bits: fails, buffer ready, cache ready
// RULE22: Status byte read after status command
`timescale 1ns/10ps
`include "nfc_consts.vh"

module nfc_host_seq (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        cmdValid,
  input  wire [2:0]  cmdOp,
  input  wire [7:0]  cmdByte,
  input  wire [12:0] columnBits,
  input  wire [17:0] rowBits,
  input  wire        protectReq,
  output reg         cmdReady,
  output reg         cmdDone,
  output reg         cmdError,
  output reg  [7:0]  rdData,
  output reg         rdValid,
  output reg         curPageFail,
  output reg         prevPageFail,
  output reg         bufReady,
  output reg         cacheReady,
  output reg         cacheProgOpen,
  output reg         chipSelect_n,
  output reg         cmdLatch,
  output reg         addrLatch,
  output reg         writeStrobe_n,
  output reg         read_strobe_n,
  output reg         writeProtect_n,
  output reg         init_select,
  output reg  [7:0]  ioBusOut,
  output reg         ioBusOe,
  input  wire [7:0]  ioBusIn,
  input  wire        ready_busy_n
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_WLOW  = 3'h1;
  localparam [2:0] S_WHIGH = 3'h2;
  localparam [2:0] S_RLOW  = 3'h3;
  localparam [2:0] S_RHIGH = 3'h4;
  localparam [2:0] S_WB    = 3'h5;
  localparam [2:0] S_WRDY  = 3'h6;

  localparam [7:0] L_WLOW = `NFC_CYC_WLOW - 8'h01;
  localparam [7:0] L_WH   = `NFC_CYC_WH - 8'h01;
  localparam [7:0] L_WHR  = `NFC_CYC_WHR - 8'h01;
  localparam [7:0] L_RLOW = `NFC_CYC_RLOW - 8'h01;
  localparam [7:0] L_REH  = `NFC_CYC_REH - 8'h01;
  localparam [7:0] L_WB   = `NFC_CYC_WB - 8'h01;

  reg [2:0] state;
  reg [7:0] cnt;
  reg [2:0] op;
  reg [7:0] opByte;
  reg [2:0] addrIdx;
  reg [2:0] addrLast;
  reg [7:0] lastCmd;
  reg       progPrefix;
  reg       refuse;

  wire [7:0] addrByte;

  // Commands the device takes while busy
  function busyOk;
    input [7:0] c;
    begin
      busyOk = (c == `NFC_CMD_STATUS) || (c == `NFC_CMD_STATMULTI) ||
               (c == `NFC_CMD_RESET);
    end
  endfunction

  // Commands that set up or confirm a program; pointless while protected
  function progCmd;
    input [7:0] c;
    begin
      progCmd = (c == `NFC_CMD_PROG) || (c == `NFC_CMD_PROGCACHE) ||
                (c == `NFC_CMD_PROGMULTI) || (c == `NFC_CMD_DATAIN) ||
                (c == `NFC_CMD_COPYPROG) || (c == `NFC_CMD_COLIN);
    end
  endfunction

  // Left open by a 15h confirm, only these keep the sequence legal
  function cacheOk;
    input [7:0] c;
    begin
      cacheOk = busyOk(c) || progCmd(c);
    end
  endfunction

  nfc_addr_pack addrPack (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .load       (cmdValid & cmdReady),
    .index      (addrIdx),
    .columnBits (columnBits),
    .rowBits    (rowBits),
    .addrByte   (addrByte)
  );

  always @* begin
    refuse = 1'b0;
    if (!ready_busy_n && cmdOp != `NFC_OP_WAIT && !(cmdOp == `NFC_OP_CMD && busyOk(cmdByte)))
      refuse = 1'b1; // RULE16 RULE17
    if (cmdOp == `NFC_OP_CMD && !writeProtect_n && progCmd(cmdByte))
      refuse = 1'b1; // RULE7
    if (cmdOp == `NFC_OP_WRITE && !writeProtect_n)
      refuse = 1'b1; // RULE3
    if ((cmdOp == `NFC_OP_ADDR5 || cmdOp == `NFC_OP_ADDR2) &&
        columnBits >= `NFC_PAGE_BYTES)
      refuse = 1'b1; // RULE11
    if (cmdOp == `NFC_OP_CMD && cacheProgOpen && !cacheOk(cmdByte))
      refuse = 1'b1; // RULE18 RULE19
    if (cmdOp > `NFC_OP_WAIT)
      refuse = 1'b1;
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state          <= S_IDLE;
      cnt            <= 8'h00;
      op             <= `NFC_OP_CMD;
      opByte         <= 8'h00;
      addrIdx        <= 3'h0;
      addrLast       <= 3'h0;
      lastCmd        <= 8'h00;
      progPrefix     <= 1'b0;
      cmdReady       <= 1'b0;
      cmdDone        <= 1'b0;
      cmdError       <= 1'b0;
      rdData         <= 8'h00;
      rdValid        <= 1'b0;
      curPageFail    <= 1'b0;
      prevPageFail   <= 1'b0;
      bufReady       <= 1'b0;
      cacheReady     <= 1'b0;
      cacheProgOpen  <= 1'b0;
      chipSelect_n   <= 1'b1;
      cmdLatch       <= 1'b0;
      addrLatch      <= 1'b0;
      writeStrobe_n  <= 1'b1;
      read_strobe_n  <= 1'b1;
      writeProtect_n <= 1'b0;
      init_select    <= `NFC_INIT_SELECT;
      ioBusOut       <= 8'h00;
      ioBusOe        <= 1'b0;
    end else begin
      cmdDone        <= 1'b0;
      cmdError       <= 1'b0;
      rdValid        <= 1'b0;
      init_select    <= `NFC_INIT_SELECT; // RULE20
      writeProtect_n <= ~protectReq; // RULE7
      case (state)
        S_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            if (refuse) begin
              cmdDone  <= 1'b1;
              cmdError <= 1'b1;
            end else begin
              op           <= cmdOp;
              opByte       <= cmdByte;
              addrIdx      <= (cmdOp == `NFC_OP_ADDR2) ? 3'h0 : 3'h0;
              addrLast     <= (cmdOp == `NFC_OP_ADDR2) ? 3'h1 : 3'h4; // RULE9
              chipSelect_n <= 1'b0;
              cnt          <= L_WLOW;
              case (cmdOp)
                `NFC_OP_CMD: begin
                  cmdLatch <= 1'b1; // RULE3
                  ioBusOut <= cmdByte;
                  ioBusOe  <= 1'b1;
                  state    <= S_WLOW;
                end
                `NFC_OP_ADDR5, `NFC_OP_ADDR2: begin
                  addrLatch <= 1'b1; // RULE3
                  ioBusOe   <= 1'b1;
                  state     <= S_WLOW;
                end
                `NFC_OP_WRITE: begin
                  ioBusOut <= cmdByte;
                  ioBusOe  <= 1'b1;
                  state    <= S_WLOW;
                end
                `NFC_OP_READ: begin
                  cnt   <= L_RLOW;
                  state <= S_RLOW;
                end
                `NFC_OP_WAIT: begin
                  cnt   <= L_WB;
                  state <= S_WB;
                end
                default: state <= S_IDLE;
              endcase
            end
          end else if (!cmdValid && ready_busy_n) begin
            chipSelect_n <= 1'b1; // RULE6
          end
        end
        S_WLOW: begin
          writeStrobe_n <= 1'b0;
          if (addrLatch)
            ioBusOut <= addrByte; // RULE9
          if (cnt == 8'h00 && !writeStrobe_n) begin
            writeStrobe_n <= 1'b1; // RULE1 RULE2
            cnt           <= cmdLatch ? L_WHR : L_WH;
            addrIdx       <= addrLatch ? addrIdx + 3'h1 : addrIdx;
            state         <= S_WHIGH;
          end else if (cnt != 8'h00 && !writeStrobe_n) begin
            cnt <= cnt - 8'h01;
          end
        end
        S_WHIGH: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else if (addrLatch && addrIdx != addrLast + 3'h1) begin
            cnt     <= L_WLOW;
            state   <= S_WLOW;
          end else begin
            cmdLatch  <= 1'b0;
            addrLatch <= 1'b0;
            ioBusOe   <= 1'b0;
            cmdDone   <= 1'b1;
            state     <= S_IDLE;
            if (op == `NFC_OP_CMD) begin
              lastCmd <= opByte;
              if (opByte == `NFC_CMD_DATAIN || opByte == `NFC_CMD_COPYPROG)
                progPrefix <= 1'b1; // RULE14 RULE15
              else if (opByte != `NFC_CMD_COLIN && !busyOk(opByte))
                progPrefix <= 1'b0;
              if (opByte == `NFC_CMD_PROGCACHE && progPrefix)
                cacheProgOpen <= 1'b1; // RULE18
              else if (opByte == `NFC_CMD_RESET ||
                       (opByte == `NFC_CMD_PROG && progPrefix))
                cacheProgOpen <= 1'b0; // RULE19
            end
          end
        end
        S_RLOW: begin
          read_strobe_n <= 1'b0; // RULE3
          if (cnt != 8'h00 && !read_strobe_n) begin
            cnt <= cnt - 8'h01;
          end else if (cnt == 8'h00 && !read_strobe_n) begin
            rdData        <= ioBusIn; // RULE4 RULE5
            read_strobe_n <= 1'b1;
            cnt           <= L_REH;
            state         <= S_RHIGH;
            if (lastCmd == `NFC_CMD_STATUS || lastCmd == `NFC_CMD_STATMULTI) begin
              curPageFail  <= ioBusIn[`NFC_ST_CUR_FAIL]; // RULE21 RULE22
              prevPageFail <= ioBusIn[`NFC_ST_PREV_FAIL];
              bufReady     <= ioBusIn[`NFC_ST_BUF_READY];
              cacheReady   <= ioBusIn[`NFC_ST_CACHE_RDY];
            end
          end
        end
        S_RHIGH: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            rdValid <= 1'b1;
            cmdDone <= 1'b1;
            state   <= S_IDLE;
          end
        end
        S_WB: begin
          // Busy may only show up to this long after the last write strobe
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else
            state <= S_WRDY;
        end
        S_WRDY: begin
          if (ready_busy_n) begin
            cmdDone <= 1'b1; // RULE8
            state   <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// ---- testbench/nfc_flash_model.sv ----
/* Behavioural model of the 8-bit page flash device.
   Clockless: reacts to strobe edges; busy time is a plain delay. */
`timescale 1ns/10ps
module nfc_flash_model #(parameter integer BUSY_NS = 403) (
  input  wire       chipSelect_n,
  input  wire       cmdLatch,
  input  wire       addrLatch,
  input  wire       writeStrobe_n,
  input  wire       read_strobe_n,
  input  wire       writeProtect_n,
  input  wire [7:0] ioBusOut,
  output wire [7:0] devIo,
  output wire       ready_busy_n
);
  reg  [7:0]  mem [0:4319];
  reg  [7:0]  adr [0:4];
  reg  [7:0]  cmd, dOut, lastIn;
  reg  [2:0]  na;
  reg  [12:0] col;
  reg         busy, stat, curFail, prevFail;
  wire [17:0] row = {adr[4][1:0], adr[3], adr[2]};
  wire [11:0] block = row[17:6];
  wire        standby = chipSelect_n && !busy;
  assign ready_busy_n = !busy;
  // Released bus shows the inverse, so a stale byte never passes
  assign devIo = (!read_strobe_n && !chipSelect_n) ? dOut : ~dOut;
  initial begin
    {busy, stat, curFail, prevFail, na, col, dOut, lastIn, cmd} = 0;
  end
  task go_busy;
    begin
      busy = 1'b1;
      busy <= #(BUSY_NS) 1'b0;
    end
  endtask
  always @(posedge writeStrobe_n) if (!chipSelect_n) begin
    if (cmdLatch && (!busy || ioBusOut == 8'h70 || ioBusOut == 8'h71 || ioBusOut == 8'hFF)) begin
      cmd = ioBusOut;
      stat = (cmd == 8'h70 || cmd == 8'h71);
      case (cmd)
        8'h00, 8'h05, 8'h80, 8'h85, 8'h8C, 8'hFF: na = 3'h0;
        8'h30, 8'h31, 8'h3F: go_busy;
        8'h10, 8'h11, 8'h15: if (writeProtect_n) begin
          prevFail = curFail;
          curFail = lastIn[0];
          go_busy;
        end
        default: ;
      endcase
    end else if (addrLatch && !busy && na < 3'h5) begin
      adr[na] = ioBusOut;
      na = na + 3'h1;
      col = {adr[1][4:0], adr[0]};
    end else if (!cmdLatch && !addrLatch && writeProtect_n && col < 13'd4320) begin
      mem[col] = ioBusOut;
      lastIn = ioBusOut;
      col = col + 13'h1;
    end
  end
  always @(negedge read_strobe_n) if (!chipSelect_n && writeStrobe_n) begin
    dOut = stat ? {1'b0, !busy, !busy, 3'h0, prevFail, curFail} : mem[col];
    if (!stat) col = col + 13'h1;
  end
endmodule

// ---- testbench/nfc_host_seq_checker.sv ----
/* Pin and request-port assertions for the flash host sequencer.
   Bound to nfc_host_seq; sees only its ports, one clock domain. */
`timescale 1ns/10ps
module nfc_host_seq_checker (
  input wire       ref_clk,
  input wire       rst,
  input wire       cmdValid,
  input wire [2:0] cmdOp,
  input wire       cmdReady,
  input wire       cmdDone,
  input wire       cmdError,
  input wire       chipSelect_n,
  input wire       cmdLatch,
  input wire       addrLatch,
  input wire       writeStrobe_n,
  input wire       read_strobe_n,
  input wire       writeProtect_n,
  input wire       init_select,
  input wire [7:0] ioBusOut,
  input wire       ioBusOe,
  input wire       ready_busy_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_latch_exclusive: assert property (!(cmdLatch && addrLatch))
    else $error("both latch strobes high");
  a_write_cycle_kind: assert property ($fell(writeStrobe_n) |-> !chipSelect_n && ioBusOe
    && (cmdLatch || addrLatch || writeProtect_n)) else $error("bad write cycle");
  a_read_cycle_kind: assert property ($fell(read_strobe_n) |-> !chipSelect_n && !cmdLatch
    && !addrLatch && writeStrobe_n && !ioBusOe) else $error("bad read cycle");
  a_write_pulse_len: assert property ($fell(writeStrobe_n) |->
    (!writeStrobe_n)[*4] ##1 writeStrobe_n) else $error("write pulse length");
  a_bus_held_low: assert property (!writeStrobe_n |=> writeStrobe_n ||
    ($stable(ioBusOut) && $stable(cmdLatch) && $stable(addrLatch))) else $error("bus moved");
  a_busy_no_read: assert property ($fell(read_strobe_n) |-> ready_busy_n)
    else $error("read strobe while busy");
  a_busy_refuse: assert property (cmdValid && cmdReady && !ready_busy_n && cmdOp != 3'h0
    && cmdOp != 3'h5 |=> cmdError && cmdDone) else $error("request taken while busy");
  a_wait_accepted: assert property (cmdValid && cmdReady && cmdOp == 3'h5
    |=> !cmdError && !cmdDone) else $error("wait request refused");
  a_protect_refuse: assert property (cmdValid && cmdReady && !writeProtect_n
    && cmdOp == 3'h3 |=> cmdError) else $error("data taken while protected");
  a_idle_release: assert property ((cmdReady && !cmdValid && ready_busy_n)[*3]
    |-> chipSelect_n) else $error("chip select held in idle");
  a_init_static: assert property ($stable(init_select))
    else $error("init select moved");
endmodule

bind nfc_host_seq nfc_host_seq_checker u_chk (.*);

// ---- testbench/nfc_host_seq_test.sv ----
/* Self-checking bench for nfc_host_seq against the flash model.
   Inputs change at the falling edge; random data from an LFSR. */
`timescale 1ns/10ps
module nfc_host_seq_test;
  localparam [63:0] CODES = 64'h05E0313F85118C10;
  reg         ref_clk, rst, cmdValid, protectReq, err, vld;
  reg  [2:0]  cmdOp;
  reg  [7:0]  cmdByte, seed, data;
  reg  [12:0] col;
  reg  [17:0] row;
  reg  [7:0]  d [0:3];
  integer     n_fail, cmp_count, i;
  wire        cmdReady, cmdDone, cmdError, rdValid, curPageFail, prevPageFail, bufReady;
  wire        cacheReady, cacheProgOpen, chipSelect_n, cmdLatch, addrLatch, writeStrobe_n;
  wire        read_strobe_n, writeProtect_n, init_select, ioBusOe, ready_busy_n;
  wire [7:0]  rdData, ioBusOut, devIo;
  wire [7:0]  ioBusIn = ioBusOe ? ioBusOut : devIo;
  nfc_host_seq dut (.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdByte(cmdByte), .columnBits(col), .rowBits(row), .protectReq(protectReq),
    .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdError(cmdError), .rdData(rdData),
    .rdValid(rdValid), .curPageFail(curPageFail), .prevPageFail(prevPageFail),
    .bufReady(bufReady), .cacheReady(cacheReady), .cacheProgOpen(cacheProgOpen),
    .chipSelect_n(chipSelect_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
    .writeProtect_n(writeProtect_n), .init_select(init_select), .ioBusOut(ioBusOut),
    .ioBusOe(ioBusOe), .ioBusIn(ioBusIn), .ready_busy_n(ready_busy_n));
  nfc_flash_model m (.chipSelect_n(chipSelect_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
    .writeProtect_n(writeProtect_n), .ioBusOut(ioBusOut), .devIo(devIo),
    .ready_busy_n(ready_busy_n));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  function [7:0] nx();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    nx = seed;
  endfunction
  function [7:0] abyte(input integer k);
    case (k)
      0: abyte = col[7:0];
      1: abyte = {3'h0, col[12:8]};
      2: abyte = row[7:0];
      3: abyte = row[15:8];
      default: abyte = {6'h00, row[17:16]};
    endcase
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Request held until taken, then answer awaited at falling edges
  task req(input [2:0] op, input [7:0] b);
    integer k;
    begin
      k = 0;
      @(negedge ref_clk);
      cmdOp = op;
      cmdByte = b;
      cmdValid = 1'b1;
      while (cmdReady !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
      cmdValid = 1'b0;
      while (cmdDone !== 1'b1 && k < 3000) begin
        @(negedge ref_clk);
        k = k + 1;
      end
      err = cmdError;
      data = rdData;
      vld = rdValid;
    end
  endtask
  task prog(input [7:0] fin);
    begin
      req(3'h0, 8'h80);
      req(3'h1, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
        d[i] = nx();
        req(3'h3, d[i]);
      end
      req(3'h0, fin);
      req(3'h5, 8'h00);
    end
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    conclude;
  end
  initial begin
    seed = 8'h48;
    {n_fail, cmp_count, i} = 0;
    {rst, cmdValid, protectReq, cmdOp, cmdByte} = 14'h2000;
    col = 13'(({nx(), nx()}) % 16'd4316);
    row = 18'({nx(), nx(), nx()});
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    prog(8'h10);
    for (i = 0; i < 5; i = i + 1) chk(m.adr[i], abyte(i));
    chk(m.block, row[17:6]);
    $display("test program done");
    req(3'h0, 8'h00);
    req(3'h1, 8'h00);
    req(3'h0, 8'h30);
    req(3'h5, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      req(3'h4, 8'h00);
      chk({vld, data}, {1'b1, d[i]});
    end
    $display("test read done");
    req(3'h0, 8'h70);
    req(3'h4, 8'h00);
    chk(data, 8'h60 | d[3][0]);
    chk({curPageFail, prevPageFail, bufReady, cacheReady}, {d[3][0], 3'h3});
    $display("test status done");
    for (i = 0; i < 8; i = i + 1) begin
      req(3'h0, CODES[63 - 8 * i -: 8]);
      chk({err, m.cmd}, {1'b0, CODES[63 - 8 * i -: 8]});
      req(3'h5, 8'h00);
    end
    $display("test codes done");
    req(3'h0, 8'h00);
    req(3'h1, 8'h00);
    req(3'h0, 8'h30);
    req(3'h4, 8'h00);
    chk(err, 1'b1);
    req(3'h0, 8'h00);
    chk(err, 1'b1);
    req(3'h0, 8'h70);
    chk(err, 1'b0);
    req(3'h5, 8'h00);
    col = 13'd4320;
    req(3'h1, 8'h00);
    chk(err, 1'b1);
    col = 13'd4319;
    req(3'h1, 8'h00);
    chk(err, 1'b0);
    col = 13'd16;
    $display("test busy and bounds done");
    protectReq = 1'b1;
    req(3'h0, 8'h80);
    chk(err, 1'b1);
    req(3'h3, nx());
    chk(err, 1'b1);
    protectReq = 1'b0;
    prog(8'h15);
    chk(cacheProgOpen, 1'b1);
    req(3'h0, 8'h00);
    chk(err, 1'b1);
    prog(8'h10);
    chk(cacheProgOpen, 1'b0);
    prog(8'h15);
    req(3'h0, 8'h70);
    req(3'h5, 8'h00);
    req(3'h0, 8'hFF);
    chk(cacheProgOpen, 1'b0);
    $display("test protect and cache done");
    conclude;
  end
endmodule
